// file: hw/tbec_pkg.sv
// Package for the timer buffer, event and interrupt control slice.
// Assumes a 32-bit Avalon-MM register port with byte addresses, one register per word.
package tbec_pkg;

    // Register word indices; byte address is four times the index
    localparam logic [5:0] TBEC_IDX_BV_CLR = 6'h06;
    localparam logic [5:0] TBEC_IDX_BV_SET = 6'h07;
    localparam logic [5:0] TBEC_IDX_EV_CTRL = 6'h09;
    localparam logic [5:0] TBEC_IDX_INT_EN = 6'h0a;
    localparam logic [5:0] TBEC_IDX_DIR_CTRL = 6'h10;
    localparam logic [5:0] TBEC_IDX_INT_FLAGS = 6'h11;

    // Event control fields
    localparam int TBEC_EVA_EN_BIT = 0;
    localparam int TBEC_EVA_ACT_LSB = 1;
    localparam int TBEC_EVB_EN_BIT = 4;
    localparam int TBEC_EVB_ACT_LSB = 5;

    // Interrupt enable fields, flags use the same layout packed as {cmp2,cmp1,cmp0,wrap}
    localparam int TBEC_INT_WRAP_BIT = 0;
    localparam int TBEC_INT_CMP_LSB = 4;
    localparam logic [7:0] TBEC_INT_EN_MASK = 8'h71;

    // Buffer-valid fields: bit 0 period, bits 3:1 compare channels
    localparam int TBEC_BV_PER_BIT = 0;
    localparam int TBEC_BV_CMP_LSB = 1;

    // Event action A codes
    localparam logic [2:0] TBEC_EVA_COUNT_RISING_EDGE = 3'h0;
    localparam logic [2:0] TBEC_EVA_COUNT_BOTH_EDGES = 3'h1;
    localparam logic [2:0] TBEC_EVA_COUNT_WHILE_HIGH = 3'h2;
    localparam logic [2:0] TBEC_EVA_STEERED = 3'h3;

    // Event action B codes
    localparam logic [2:0] TBEC_EVB_NONE = 3'h0;
    localparam logic [2:0] TBEC_EVB_STEERED = 3'h3;
    localparam logic [2:0] TBEC_EVB_RESTART_RISING = 3'h4;
    localparam logic [2:0] TBEC_EVB_RESTART_BOTH_EDGES = 3'h5;
    localparam logic [2:0] TBEC_EVB_RESTART_WHILE_HIGH = 3'h6;

    // Reset values
    localparam logic [7:0] TBEC_EV_CTRL_RST = 8'h00;
    localparam logic [7:0] TBEC_INT_EN_RST = 8'h00;
    localparam logic [3:0] TBEC_BV_RST = 4'h0;
    localparam logic [3:0] TBEC_FLAGS_RST = 4'h0;
    localparam logic TBEC_DIR_RST = 1'b0;

    // Status from the counter core
    typedef struct packed {
        logic period_buffer_write;
        logic [2:0] compare_buffer_write;
        logic update_event;
        logic [2:0] compare_match;
        logic wrap_event;
        logic hw_dir_up;
        logic hw_dir_down;
        logic prescaled_tick;
    } tbec_core_in_t;

    // Event-system channel levels
    typedef struct packed {
        logic event_a;
        logic event_b;
    } tbec_events_t;

    // Controls handed back to the counter core
    typedef struct packed {
        logic count_step;
        logic count_down;
        logic restart;
    } tbec_core_out_t;

    typedef struct packed {
        logic dir;
        logic [3:0] buffer_valid;
        logic [3:0] flags;
        logic [7:0] event_input_control;
        logic [7:0] interrupt_enable;
        logic prev_a;
        logic prev_b;
        logic ack;
        logic [31:0] rdata;
        logic count_step;
        logic restart;
        logic [2:0] compare_channel_irq;
        logic wrap_irq;
    } tbec_state_t;

endpackage

// file: hw/tbec_control.sv
// Buffer-valid, event-action and interrupt control slice of a 16-bit timer/counter.
// Assumes the counter core supplies buffer writes, update, match and wrap pulses,
// and event inputs synchronous to mclk.
// Function
// R1 - Direction bit zero counts up, one counts down.
// R2 - Direction follows hardware and event actions, software writes also take effect.
// R3 - Writing one to clear register clears that buffer-valid flag.
// R4 - Writing one to set register sets that buffer-valid flag.
// R5 - Compare buffer write sets that channel's buffer-valid flag, bits 1 to 3.
// R6 - Update condition clears all compare buffer-valid flags.
// R7 - Period buffer write sets the period buffer-valid flag, bit 0.
// R8 - Update condition clears the period buffer-valid flag.
// R9 - Event input A enable applies the selected event action A.
// R10 - Event input B enable applies the selected event action B.
// R11 - Action A 0 counts rising edges, 1 counts both edges.
// R12 - Action A 2 counts prescaled clocks while event A high.
// R13 - Action A 3 counts prescaled clocks, A low up, high down, latched.
// R14 - Action B 3 counts per input A setting, B steers direction, latched.
// R15 - Action B 4 restarts on rising edge, 5 on either edge.
// R16 - Action B 6 holds restart while event B high.
// R17 - Compare interrupt enable bits 4 to 6 allow compare interrupts.
// R18 - Enable bit 0 allows the overflow/underflow interrupt.
// R19 - Compare match sets compare flag until software writes one.
// R20 - Wrap event sets overflow/underflow flag at mode's top or bottom.
// R21 - Interrupt request asserted while flag and enable both set.
// R22 - Reserved codes and action B zero change nothing.
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module tbec_control
    import tbec_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int NUM_CMP = 3
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire tbec_core_in_t core_in,
    input wire tbec_events_t events,
    output tbec_core_out_t core_out,
    output logic [NUM_CMP-1:0] compare_channel_irq,
    output logic wrap_irq
);

    // The register index is taken from address bits 7:2, so eight address bits are the minimum
    if (ADDR_W < 8 || NUM_CMP != 3) begin : g_bad_param
        $error("tbec_control: ADDR_W must be at least 8 and NUM_CMP must be 3");
    end

    tbec_state_t st;
    tbec_state_t next_st;

    // Edge of an event level: rising only, or both polarities
    function automatic logic edge_of(input logic cur, input logic prev, input logic both);
        edge_of = both ? (cur ^ prev) : (cur & ~prev);
    endfunction

    function automatic logic [31:0] reg_read(input logic [5:0] idx, input tbec_state_t s);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (idx == TBEC_IDX_BV_CLR || idx == TBEC_IDX_BV_SET) begin
            v[3:0] = s.buffer_valid;
        end else if (idx == TBEC_IDX_EV_CTRL) begin
            v[7:0] = s.event_input_control;
        end else if (idx == TBEC_IDX_INT_EN) begin
            v[7:0] = s.interrupt_enable;
        end else if (idx == TBEC_IDX_DIR_CTRL) begin
            v[0] = s.dir;
        end else if (idx == TBEC_IDX_INT_FLAGS) begin
            v[TBEC_INT_WRAP_BIT] = s.flags[0];
            v[TBEC_INT_CMP_LSB +: 3] = s.flags[3:1];
        end
        reg_read = v;
    endfunction

    logic [5:0] idx;
    logic [7:0] wdat;
    logic wr_go;
    logic eva_en;
    logic evb_en;
    logic [2:0] act_a;
    logic [2:0] act_b;
    logic a_step;
    logic restart_now;
    logic step_now;
    logic [3:0] bv_clr;
    logic [3:0] bv_set;
    logic [3:0] flag_clr;
    logic [3:0] flag_set;

    assign idx = address[7:2];
    assign wdat = writedata[7:0];
    // One wait state: request taken when ack is high, write takes effect at that edge
    assign waitrequest = (read | write) & ~st.ack;
    assign wr_go = write & st.ack & byteenable[0];
    assign eva_en = st.event_input_control[TBEC_EVA_EN_BIT];
    assign evb_en = st.event_input_control[TBEC_EVB_EN_BIT];
    assign act_a = st.event_input_control[TBEC_EVA_ACT_LSB +: 3];
    assign act_b = st.event_input_control[TBEC_EVB_ACT_LSB +: 3];

    always_comb begin
        next_st = st;
        bv_clr = 4'h0;
        bv_set = 4'h0;
        flag_clr = 4'h0;
        flag_set = {core_in.compare_match, core_in.wrap_event}; // R19 R20

        // Register access
        next_st.ack = (read | write) & ~st.ack;
        if (read && !st.ack) begin
            next_st.rdata = reg_read(idx, st);
        end
        if (wr_go) begin
            if (idx == TBEC_IDX_BV_CLR) begin
                bv_clr = wdat[3:0]; // R3
            end else if (idx == TBEC_IDX_BV_SET) begin
                bv_set = wdat[3:0]; // R4
            end else if (idx == TBEC_IDX_EV_CTRL) begin
                next_st.event_input_control = wdat;
            end else if (idx == TBEC_IDX_INT_EN) begin
                next_st.interrupt_enable = wdat & TBEC_INT_EN_MASK; // R17 R18
            end else if (idx == TBEC_IDX_INT_FLAGS) begin
                flag_clr = {wdat[TBEC_INT_CMP_LSB +: 3], wdat[TBEC_INT_WRAP_BIT]};
            end
        end

        // Buffer-valid: hardware and W1S sets win over update and W1C clears
        next_st.buffer_valid = (st.buffer_valid & ~bv_clr & ~{4{core_in.update_event}}) // R6 R8
                               | bv_set
                               | {core_in.compare_buffer_write, core_in.period_buffer_write}; // R5 R7
        // Interrupt flags: a new event wins over a clear in the same cycle
        next_st.flags = (st.flags & ~flag_clr) | flag_set; // R19

        // Count source from event A, prescaled clock when disabled or reserved
        a_step = core_in.prescaled_tick;
        if (eva_en) begin // R9
            case (act_a)
                TBEC_EVA_COUNT_RISING_EDGE: a_step = edge_of(events.event_a, st.prev_a, 1'b0); // R11
                TBEC_EVA_COUNT_BOTH_EDGES: a_step = edge_of(events.event_a, st.prev_a, 1'b1); // R11
                TBEC_EVA_COUNT_WHILE_HIGH: a_step = core_in.prescaled_tick & events.event_a; // R12
                TBEC_EVA_STEERED: a_step = core_in.prescaled_tick; // R13
                default: a_step = core_in.prescaled_tick; // R22
            endcase
        end

        // Restart from event B
        restart_now = 1'b0;
        if (evb_en) begin // R10
            case (act_b)
                TBEC_EVB_RESTART_RISING: restart_now = edge_of(events.event_b, st.prev_b, 1'b0); // R15
                TBEC_EVB_RESTART_BOTH_EDGES: restart_now = edge_of(events.event_b, st.prev_b, 1'b1); // R15
                TBEC_EVB_RESTART_WHILE_HIGH: restart_now = events.event_b; // R16
                default: restart_now = 1'b0; // R22
            endcase
        end
        step_now = a_step & ~restart_now;
        next_st.count_step = step_now;
        next_st.restart = restart_now;

        // Direction: waveform mode, then software, then event steering latched at a count
        if (core_in.hw_dir_up) begin
            next_st.dir = 1'b0; // R2
        end else if (core_in.hw_dir_down) begin
            next_st.dir = 1'b1; // R2
        end
        if (wr_go && idx == TBEC_IDX_DIR_CTRL) begin
            next_st.dir = wdat[0]; // R2
        end
        if (step_now && evb_en && act_b == TBEC_EVB_STEERED) begin
            next_st.dir = events.event_b; // R14
        end else if (step_now && eva_en && act_a == TBEC_EVA_STEERED) begin
            next_st.dir = events.event_a; // R13
        end

        next_st.prev_a = events.event_a;
        next_st.prev_b = events.event_b;

        // Requests follow the new flag and enable values together
        next_st.compare_channel_irq = next_st.flags[3:1]
                                      & next_st.interrupt_enable[TBEC_INT_CMP_LSB +: 3]; // R21
        next_st.wrap_irq = next_st.flags[0] & next_st.interrupt_enable[TBEC_INT_WRAP_BIT]; // R21
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
            st.dir <= TBEC_DIR_RST;
            st.buffer_valid <= TBEC_BV_RST;
            st.flags <= TBEC_FLAGS_RST;
            st.event_input_control <= TBEC_EV_CTRL_RST;
            st.interrupt_enable <= TBEC_INT_EN_RST;
        end else begin
            st <= next_st;
        end
    end

    assign readdata = st.rdata;
    assign core_out.count_step = st.count_step;
    assign core_out.count_down = st.dir; // R1
    assign core_out.restart = st.restart;
    assign compare_channel_irq = st.compare_channel_irq;
    assign wrap_irq = st.wrap_irq;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    property p_period_bv_set;
        core_in.period_buffer_write |=> st.buffer_valid[TBEC_BV_PER_BIT];
    endproperty
    a_period_bv_set: assert property (p_period_bv_set) else $error("period buffer-valid not set"); // R7

    property p_cmp_bv_set;
        |core_in.compare_buffer_write
            |=> (st.buffer_valid[TBEC_BV_CMP_LSB +: 3] & $past(core_in.compare_buffer_write))
                == $past(core_in.compare_buffer_write);
    endproperty
    a_cmp_bv_set: assert property (p_cmp_bv_set) else $error("compare buffer-valid not set"); // R5

    property p_update_clears;
        core_in.update_event && core_in.compare_buffer_write == 3'h0 && !core_in.period_buffer_write
            && !(wr_go && idx == TBEC_IDX_BV_SET) |=> st.buffer_valid == 4'h0;
    endproperty
    a_update_clears: assert property (p_update_clears) else $error("update left a buffer-valid set"); // R6

    property p_w1c;
        wr_go && idx == TBEC_IDX_BV_CLR && wdat[0] && !core_in.period_buffer_write
            |=> !st.buffer_valid[0] && $stable(st.event_input_control);
    endproperty
    a_w1c: assert property (p_w1c) else $error("write-one-to-clear failed"); // R3

    property p_w1s;
        wr_go && idx == TBEC_IDX_BV_SET && wdat[2] |=> st.buffer_valid[2];
    endproperty
    a_w1s: assert property (p_w1s) else $error("write-one-to-set failed"); // R4

    property p_rise_count;
        eva_en && act_a == TBEC_EVA_COUNT_RISING_EDGE && events.event_a && !st.prev_a && !restart_now
            |=> core_out.count_step;
    endproperty
    a_rise_count: assert property (p_rise_count) else $error("rising edge of event A did not count"); // R11

    property p_restart_high;
        evb_en && act_b == TBEC_EVB_RESTART_WHILE_HIGH && events.event_b
            |=> core_out.restart && !core_out.count_step;
    endproperty
    a_restart_high: assert property (p_restart_high) else $error("restart not held while event B high"); // R16

    property p_steer_a;
        eva_en && act_a == TBEC_EVA_STEERED && !(evb_en && act_b == TBEC_EVB_STEERED)
            && core_in.prescaled_tick && !restart_now |=> core_out.count_down == $past(events.event_a);
    endproperty
    a_steer_a: assert property (p_steer_a) else $error("event A did not steer direction"); // R13

    property p_cmp_flag;
        core_in.compare_match[0] |=> st.flags[1] ##1 (st.flags[1] || $past(wr_go));
    endproperty
    a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag not held"); // R19

    property p_irq_gate;
        compare_channel_irq == (st.flags[3:1] & st.interrupt_enable[6:4])
            && wrap_irq == (st.flags[0] & st.interrupt_enable[0]);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt request not flag and enable"); // R21

    property p_b_none;
        !evb_en || act_b == TBEC_EVB_NONE |=> !core_out.restart;
    endproperty
    a_b_none: assert property (p_b_none) else $error("restart without restart action"); // R22

endmodule

// file: tb/tbec_partner.sv
// Event-system channel and counter-core stand-in for the control slice.
// Assumes requests from the bench change just after a rising mclk edge.
`timescale 1ns/100ps
module tbec_partner
    import tbec_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire tbec_core_in_t req,
    input wire tbec_events_t lvl,
    output tbec_core_in_t core_in,
    output tbec_events_t events
);
    // Channels are registered, so pulses last one cycle and levels move on edges
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            core_in <= '0;
            events <= '0;
        end else begin
            core_in <= req;
            events <= lvl;
        end
    end
endmodule

// file: tb/timer_buffer_event_irq_control_test.sv
// Self-checking bench for the timer buffer, event and interrupt control slice.
// Assumes the one-wait-state register port and one-cycle output latency of the slice.
`timescale 1ns/100ps
module timer_buffer_event_irq_control_test;
    import tbec_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] readdata;
    logic waitrequest;
    tbec_core_in_t req = '0;
    tbec_events_t lvl = '0;
    tbec_core_in_t core_in;
    tbec_events_t events;
    tbec_core_out_t core_out;
    logic [2:0] compare_channel_irq;
    logic wrap_irq;
    integer bad_count = 0;
    integer checks = 0;
    integer seed = 32'h9a97;
    integer steps = 0;
    integer rsts = 0;
    integer s0;
    logic [7:0] q;
    logic [7:0] m;
    logic [5:0] ids [7] = '{6'h06, 6'h07, 6'h09, 6'h0a, 6'h10, 6'h11, 6'h20};

    always #10 mclk = ~mclk;

    always @(posedge mclk) begin
        steps <= steps + core_out.count_step;
        rsts <= rsts + core_out.restart;
    end

    tbec_partner u_tbec_partner (.mclk(mclk), .arst_n(arst_n), .req(req), .lvl(lvl), .core_in(core_in),
        .events(events));

    tbec_control #(.ADDR_W(8), .NUM_CMP(3)) u_tbec_control (.mclk(mclk), .arst_n(arst_n), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .core_in(core_in), .events(events), .core_out(core_out),
        .compare_channel_irq(compare_channel_irq), .wrap_irq(wrap_irq));

    task final_report;
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", n, exp, got);
            bad_count++;
        end
    endtask

    task bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        address <= {idx, 2'b00};
        read <= !wr;
        write <= wr;
        writedata <= {24'h0, d};
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 50) begin
            chk("bus timeout", 1, 0);
            final_report();
        end
    endtask

    task wr(input logic [5:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task rd_chk(input logic [5:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk($sformatf("reg %h", idx), {24'h0, q}, {24'h0, exp});
    endtask

    task pulse(input tbec_core_in_t p);
        @(posedge mclk);
        req <= p;
        @(posedge mclk);
        req <= '0;
        repeat (3) @(posedge mclk);
    endtask

    // Holds both event levels for n cycles, with a tick on every other cycle
    task hold(input logic ea, input logic eb, input int n, input logic tk);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            lvl <= {ea, eb};
            req.prescaled_tick <= tk & i[0];
        end
        @(posedge mclk);
        req.prescaled_tick <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    function automatic int exp_a(int en, int c);
        if (en == 0 || c > 3 || c == 3) return 4;
        if (c == 1 || c == 2) return 2;
        return 1;
    endfunction

    function automatic int exp_b(int c);
        if (c == 4) return 1;
        if (c == 5) return 2;
        if (c == 6) return 8;
        return 0;
    endfunction

    initial begin
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        for (int i = 0; i < 7; i++) rd_chk(ids[i], 8'h00);
        wr(6'h20, 8'hff);
        rd_chk(6'h20, 8'h00);
        $display("test reset_map done");
        m = 8'($random(seed)) | 8'h01;
        wr(TBEC_IDX_BV_SET, m);
        rd_chk(TBEC_IDX_BV_CLR, m & 8'h0f);
        wr(TBEC_IDX_BV_CLR, 8'h05);
        rd_chk(TBEC_IDX_BV_SET, m & 8'h0a);
        byteenable <= 4'h0;
        wr(TBEC_IDX_BV_SET, 8'h0f);
        byteenable <= 4'hf;
        rd_chk(TBEC_IDX_BV_SET, m & 8'h0a);
        wr(TBEC_IDX_BV_SET, 8'h04);
        rd_chk(TBEC_IDX_BV_CLR, (m & 8'h0a) | 8'h04);
        wr(TBEC_IDX_BV_CLR, 8'h0f);
        pulse({1'b1, m[2:0], 8'h00});
        rd_chk(TBEC_IDX_BV_CLR, {4'h0, m[2:0], 1'b1});
        pulse(12'h080);
        rd_chk(TBEC_IDX_BV_CLR, 8'h00);
        $display("test buffer_valid done");
        wr(TBEC_IDX_INT_EN, 8'hff);
        rd_chk(TBEC_IDX_INT_EN, TBEC_INT_EN_MASK);
        wr(TBEC_IDX_INT_EN, 8'h01);
        pulse({5'h0, m[2:0], 4'h8});
        chk("wrap_irq", wrap_irq, 1);
        chk("compare_channel_irq", compare_channel_irq, 0);
        rd_chk(TBEC_IDX_INT_FLAGS, {1'b0, m[2:0], 4'h1});
        wr(TBEC_IDX_INT_EN, 8'h71);
        repeat (2) @(posedge mclk);
        chk("compare_channel_irq", compare_channel_irq, m[2:0]);
        wr(TBEC_IDX_INT_FLAGS, 8'h71);
        repeat (2) @(posedge mclk);
        chk("compare_channel_irq", compare_channel_irq, 0);
        chk("wrap_irq", wrap_irq, 0);
        $display("test interrupts done");
        wr(TBEC_IDX_DIR_CTRL, 8'h01);
        repeat (2) @(posedge mclk);
        chk("count_down", core_out.count_down, 1);
        pulse(12'h004);
        chk("count_down", core_out.count_down, 0);
        pulse(12'h002);
        rd_chk(TBEC_IDX_DIR_CTRL, 8'h01);
        chk("count_down", core_out.count_down, 1);
        wr(TBEC_IDX_DIR_CTRL, 8'h00);
        repeat (2) @(posedge mclk);
        chk("count_down", core_out.count_down, 0);
        $display("test direction done");
        for (int k = 0; k < 9; k++) begin
            wr(TBEC_IDX_EV_CTRL, {4'h0, k[2:0], 1'(k < 8)});
            s0 = steps;
            hold(1'b1, 1'b0, 4, 1'b1);
            if (k == 3) chk("count_down", core_out.count_down, 1);
            hold(1'b0, 1'b0, 4, 1'b1);
            if (k == 3) chk("count_down", core_out.count_down, 0);
            chk($sformatf("steps a%0d", k), steps - s0, exp_a(k < 8, k));
        end
        $display("test event_a done");
        for (int k = 0; k < 8; k++) begin
            wr(TBEC_IDX_EV_CTRL, {k[2:0], 5'h10});
            s0 = rsts;
            hold(1'b0, 1'b1, 4, 1'(k == 3));
            if (k == 3) chk("count_down", core_out.count_down, 1);
            hold(1'b0, 1'b0, 4, 1'(k == 3));
            if (k == 3) chk("count_down", core_out.count_down, 0);
            chk($sformatf("restarts b%0d", k), rsts - s0, exp_b(k));
        end
        $display("test event_b done");
        // Mid-run reset must return the control registers to zero
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        rd_chk(TBEC_IDX_EV_CTRL, 8'h00);
        rd_chk(TBEC_IDX_INT_EN, 8'h00);
        chk("count_down", core_out.count_down, 0);
        $display("test reset_again done");
        final_report();
    end
endmodule
